// [hdl/dma_status_pkg.sv]
// Purpose: Shared constants for the DMA channel status bank
// Assumes: APB with 32-bit data, byte addresses, word-aligned registers
// Notes: Per-channel fields sit at fixed bit positions
package dma_status_pkg;

    localparam int MAX_CHANNELS = 8;
    localparam int ADDR_WIDTH = 12;
    localparam int DATA_WIDTH = 32;

    // ==========================================================
    // Register byte offsets
    localparam logic [11:0] OFF_IRQ_STATUS = 12'h00C;
    localparam logic [11:0] OFF_IRQ_CLEAR = 12'h010;
    localparam logic [11:0] OFF_TC_STATUS = 12'h014;
    localparam logic [11:0] OFF_FAULT_ABORT = 12'h018;
    localparam logic [11:0] OFF_CHAN_ON = 12'h01C;
    localparam logic [11:0] OFF_CHAN_ACTIVE = 12'h020;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h040;
    localparam logic [11:0] OFF_TC_CLEAR = 12'h044;

    // ==========================================================
    // Field positions
    localparam int FAULT_LSB = 0;
    localparam int ABORT_LSB = 16;
    localparam int WORD_LSB = 2;

    // ==========================================================
    // Reset values
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [31:0] WORD_RESET = 32'h00000000;
    localparam logic [7:0] MASK_RESET = 8'h00;

endpackage

// [hdl/flag_bank_if.sv]
// Purpose: Carrier between the status bank top and its flag banks
// Assumes: One clock domain
// Notes: One instance per event kind
`timescale 1ns/1ps
interface flag_bank_if #(parameter int CHANNELS = 8);
    logic [CHANNELS-1:0] set;
    logic [CHANNELS-1:0] clear;
    logic [CHANNELS-1:0] mask;
    logic [CHANNELS-1:0] flag;
    logic [CHANNELS-1:0] pending;

    modport bank (input set, input clear, input mask, output flag, output pending);
    modport user (output set, output clear, output mask, input flag, input pending);
endinterface

// [hdl/channel_flag_bank.sv]
// Purpose: Sticky per-channel event flags with masked pending view
// Assumes: Set and clear are one-cycle, same-clock strobes
// Notes: Set wins over a clear in the same cycle
`timescale 1ns/1ps
module channel_flag_bank
    import dma_status_pkg::*;
#(
    parameter int CHANNELS = MAX_CHANNELS
) (
    input wire logic pclk, // Bus clock
    input wire logic presetn, // Async reset, active low
    flag_bank_if.bank bank // Set, clear, mask, flags
);

    // ==========================================================
    // Sticky flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank.flag <= CHANNELS'(FLAGS_RESET);
        end else begin
            bank.flag <= (bank.flag & ~bank.clear) | bank.set;
        end
    end

    // Mask hides pending status only
    assign bank.pending = bank.flag & ~bank.mask;

endmodule

// [hdl/dma_channel_status_bank.sv]
// Purpose: Status register group of an eight-channel DMA controller
// Assumes: Event and control inputs come from logic on pclk
// Notes: Zero-wait APB slave; unmapped addresses answer pslverr
//
// Behaviour
// - Terminal-count flag sets only while its mask is clear; reads zero when masked.
// - Terminal-count status at 0x014, bits 7..0 per channel, read only.
// - Bus error response stops the transfer and sets the channel fault flag.
// - Unmasked fault sets masked fault bit, raises fault and combined interrupt.
// - Abort control bit stops the transfer and sets the channel abort flag.
// - Unmasked abort sets masked abort bit and raises only combined interrupt.
// - Fault/abort status at 0x018: abort bits 23..16, fault bits 7..0.
// - Bits 31..24 and 15..8 read zero, plus unbuilt channel bits.
// - Channel-on status at 0x01C mirrors each channel's enable bit.
// - Channel-active status at 0x020 mirrors each channel's busy bit.
// - Unbuilt channel bits read zero; all status bits reset to zero. Channel-on and channel-active bits are not reset; they mirror their inputs.
// - Writing one to clear bits 7..0 clears fault flag and masked bit.
// - Writing one to clear bits 23..16 clears abort flag and masked bit.
// - Fault interrupt high while any masked fault bit is set.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
module dma_channel_status_bank
    import dma_status_pkg::*;
#(
    parameter int CHANNELS = MAX_CHANNELS
) (
    input wire logic pclk, // Bus clock, 40 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write when high
    input wire logic [ADDR_WIDTH-1:0] paddr, // APB byte address
    input wire logic [DATA_WIDTH-1:0] pwdata, // APB write data
    output logic [DATA_WIDTH-1:0] prdata, // APB read data, registered
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic [CHANNELS-1:0] terminal_count_event, // Terminal count pulse per channel
    input wire logic [CHANNELS-1:0] terminal_count_mask, // Terminal-count mask per channel
    input wire logic [CHANNELS-1:0] bus_error_event, // Bus error during transfer
    input wire logic [CHANNELS-1:0] abort_request, // Abort control bit per channel
    input wire logic [CHANNELS-1:0] channel_on_bit, // Channel enable bits
    input wire logic [CHANNELS-1:0] channel_active_bit, // Channel busy bits
    output logic [CHANNELS-1:0] stop_transfer, // Stop strobe per channel, registered
    output logic fault_irq, // Fault interrupt, level
    output logic dma_irq // Combined interrupt, level
);

    // ==========================================================
    // Helpers
    function automatic logic hits(input logic [ADDR_WIDTH-1:0] addr, input logic [11:0] off);
        hits = (addr[ADDR_WIDTH-1:WORD_LSB] == off[ADDR_WIDTH-1:WORD_LSB]);
    endfunction

    function automatic logic [DATA_WIDTH-1:0] low_field(input logic [CHANNELS-1:0] bits);
        logic [DATA_WIDTH-1:0] w;
        w = WORD_RESET;
        w[FAULT_LSB +: CHANNELS] = bits;
        low_field = w;
    endfunction

    function automatic logic [DATA_WIDTH-1:0] pair_field(input logic [CHANNELS-1:0] hi,
                                                         input logic [CHANNELS-1:0] lo);
        logic [DATA_WIDTH-1:0] w;
        w = WORD_RESET;
        w[ABORT_LSB +: CHANNELS] = hi;
        w[FAULT_LSB +: CHANNELS] = lo;
        pair_field = w;
    endfunction

    // ==========================================================
    // Bus phase decode
    logic setup_phase;
    logic write_access;
    logic mapped;
    logic sel_irq_clear;
    logic sel_irq_mask;
    logic sel_tc_clear;

    assign setup_phase = psel && !penable;
    assign write_access = psel && penable && pwrite;

    always_comb begin
        mapped = 1'b1;
        sel_irq_clear = 1'b0;
        sel_irq_mask = 1'b0;
        sel_tc_clear = 1'b0;
        if (hits(paddr, OFF_IRQ_CLEAR)) begin
            sel_irq_clear = 1'b1;
        end else if (hits(paddr, OFF_IRQ_MASK)) begin
            sel_irq_mask = 1'b1;
        end else if (hits(paddr, OFF_TC_CLEAR)) begin
            sel_tc_clear = 1'b1;
        end else if (hits(paddr, OFF_IRQ_STATUS) || hits(paddr, OFF_TC_STATUS) ||
                     hits(paddr, OFF_FAULT_ABORT) || hits(paddr, OFF_CHAN_ON) ||
                     hits(paddr, OFF_CHAN_ACTIVE)) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // ==========================================================
    // Interrupt mask register
    logic [CHANNELS-1:0] fault_irq_mask;
    logic [CHANNELS-1:0] abort_irq_mask;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_irq_mask <= CHANNELS'(MASK_RESET);
            abort_irq_mask <= CHANNELS'(MASK_RESET);
        end else if (write_access && sel_irq_mask) begin
            fault_irq_mask <= pwdata[FAULT_LSB +: CHANNELS];
            abort_irq_mask <= pwdata[ABORT_LSB +: CHANNELS];
        end
    end

    // ==========================================================
    // Flag banks
    flag_bank_if #(.CHANNELS(CHANNELS)) tc_if ();
    flag_bank_if #(.CHANNELS(CHANNELS)) fault_if ();
    flag_bank_if #(.CHANNELS(CHANNELS)) abort_if ();

    assign tc_if.set = terminal_count_event & ~terminal_count_mask;
    assign tc_if.clear = (write_access && sel_tc_clear) ? pwdata[FAULT_LSB +: CHANNELS] : '0;
    assign tc_if.mask = terminal_count_mask;

    assign fault_if.set = bus_error_event;
    assign fault_if.clear = (write_access && sel_irq_clear) ? pwdata[FAULT_LSB +: CHANNELS] : '0;
    assign fault_if.mask = fault_irq_mask;

    assign abort_if.set = abort_request;
    assign abort_if.clear = (write_access && sel_irq_clear) ? pwdata[ABORT_LSB +: CHANNELS] : '0;
    assign abort_if.mask = abort_irq_mask;

    channel_flag_bank #(.CHANNELS(CHANNELS)) tc_bank (
        .pclk(pclk),
        .presetn(presetn),
        .bank(tc_if)
    );

    channel_flag_bank #(.CHANNELS(CHANNELS)) fault_bank (
        .pclk(pclk),
        .presetn(presetn),
        .bank(fault_if)
    );

    channel_flag_bank #(.CHANNELS(CHANNELS)) abort_bank (
        .pclk(pclk),
        .presetn(presetn),
        .bank(abort_if)
    );

    // ==========================================================
    // Transfer stop strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_transfer <= CHANNELS'(FLAGS_RESET);
        end else begin
            stop_transfer <= bus_error_event | abort_request;
        end
    end

    // ==========================================================
    // Interrupt outputs
    // fault interrupt level
    assign fault_irq = |fault_if.pending;
    assign dma_irq = |fault_if.pending || |abort_if.pending || |tc_if.pending;

    // ==========================================================
    // Read data
    logic [DATA_WIDTH-1:0] next_prdata;

    always_comb begin
        next_prdata = WORD_RESET;
        if (hits(paddr, OFF_IRQ_STATUS)) begin
            next_prdata = pair_field(abort_if.pending, fault_if.pending);
        end else if (hits(paddr, OFF_TC_STATUS)) begin
            next_prdata = low_field(tc_if.pending);
        end else if (hits(paddr, OFF_FAULT_ABORT)) begin
            next_prdata = pair_field(abort_if.flag, fault_if.flag);
        end else if (hits(paddr, OFF_CHAN_ON)) begin
            next_prdata = low_field(channel_on_bit);
        end else if (hits(paddr, OFF_CHAN_ACTIVE)) begin
            next_prdata = low_field(channel_active_bit);
        end else if (hits(paddr, OFF_IRQ_MASK)) begin
            next_prdata = pair_field(abort_irq_mask, fault_irq_mask);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= WORD_RESET;
        end else if (setup_phase && !pwrite) begin
            prdata <= next_prdata;
        end
    end

endmodule

// [tb/dma_status_props.sv]
// Purpose: Port checker for the DMA channel status bank
// Assumes: Irq masks shadowed from APB writes to the mask register
// Notes: Attached by bind below
`timescale 1ns/1ps
module dma_status_props
    import dma_status_pkg::*;
#(
    parameter int CHANNELS = MAX_CHANNELS
) (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset
    input wire logic psel, // APB
    input wire logic penable, // APB
    input wire logic pwrite, // APB
    input wire logic [ADDR_WIDTH-1:0] paddr, // APB
    input wire logic [DATA_WIDTH-1:0] pwdata, // APB
    input wire logic pready, // APB
    input wire logic pslverr, // APB
    input wire logic [CHANNELS-1:0] bus_error_event, // Fault in
    input wire logic [CHANNELS-1:0] abort_request, // Abort in
    input wire logic [CHANNELS-1:0] stop_transfer, // Stop out
    input wire logic fault_irq, // Irq
    input wire logic dma_irq // Irq
);
    logic [CHANNELS-1:0] fm;
    logic [CHANNELS-1:0] am;
    wire [11:0] a = {paddr[11:2], 2'b00};
    wire wr_acc = psel && penable && pwrite;
    wire ro = a inside {OFF_IRQ_STATUS, OFF_TC_STATUS, OFF_FAULT_ABORT, OFF_CHAN_ON, OFF_CHAN_ACTIVE};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fm <= '0;
            am <= '0;
        end else if (wr_acc && a == OFF_IRQ_MASK) begin
            fm <= pwdata[CHANNELS-1:0];
            am <= pwdata[ABORT_LSB+:CHANNELS];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_fault_in;
        (bus_error_event & ~fm) != '0;
    endsequence
    sequence s_both_irq;
        fault_irq && dma_irq;
    endsequence
    a_stop_follows: assert property ((|bus_error_event) || (|abort_request) |=>
        stop_transfer == ($past(bus_error_event) | $past(abort_request))) else $error("stop strobe wrong");
    a_stop_quiet: assert property (!(|bus_error_event) && !(|abort_request) |=> stop_transfer == '0)
        else $error("stray stop strobe");
    a_fault_irq_up: assert property (s_fault_in |=> s_both_irq) else $error("fault irq not raised");
    a_abort_irq_up: assert property ((abort_request & ~am) != '0 |=> dma_irq) else $error("abort irq missing");
    a_abort_no_fault: assert property ((|abort_request) && !(|bus_error_event) && !fault_irq && !wr_acc
        |=> !fault_irq) else $error("abort raised fault irq");
    a_fault_irq_holds: assert property (fault_irq && !wr_acc |=> fault_irq) else $error("fault irq dropped");
    a_fault_in_combined: assert property (fault_irq |-> dma_irq) else $error("combined irq low");
    a_ro_no_error: assert property (psel && penable && ro |-> pready && !pslverr) else $error("ro access error");
    a_reset_quiet: assert property ($rose(presetn) |-> !fault_irq && !dma_irq && stop_transfer == '0)
        else $error("outputs not clear after reset");
endmodule
bind dma_channel_status_bank dma_status_props #(.CHANNELS(CHANNELS)) u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .bus_error_event(bus_error_event), .abort_request(abort_request),
    .stop_transfer(stop_transfer), .fault_irq(fault_irq), .dma_irq(dma_irq));

// [tb/dma_channel_status_bank_tb.sv]
// Purpose: Directed bench for the DMA channel status bank
// Assumes: Zero-wait APB slave, eight channels
// Notes: Events are one-cycle pulses
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; $display("Error at %0t: mismatch, got %h expected %h", $time, g, e); end end
module dma_channel_status_bank_tb
    import dma_status_pkg::*;
;
    logic pclk;
    logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, rd, prdata;
    logic [7:0] tce = '0, tcm = '0, bee = '0, abr = '0, onb = '0, act = '0, stop;
    logic pready, pslverr, fault_irq, dma_irq;
    int failures = 0, compares = 0;
    dma_channel_status_bank DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .terminal_count_event(tce), .terminal_count_mask(tcm), .bus_error_event(bee), .abort_request(abr),
        .channel_on_bit(onb), .channel_active_bit(act), .stop_transfer(stop), .fault_irq(fault_irq),
        .dma_irq(dma_irq));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // ==========================================================
    // Bus and event tasks
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask
    task fire(input logic [7:0] e, input logic [7:0] b, input logic [7:0] t);
        bee <= e;
        abr <= b;
        tce <= t;
        @(posedge pclk);
        bee <= 8'h00;
        abr <= 8'h00;
        tce <= 8'h00;
        @(negedge pclk);
        `CHK(stop, e | b)
        @(posedge pclk);
    endtask
    task irq(input logic f, input logic d);
        @(negedge pclk);
        `CHK(fault_irq, f)
        `CHK(dma_irq, d)
        @(posedge pclk);
    endtask
    task final_report;
        $display("Compares %0d, failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #50000;
        failures++;
        final_report;
    end
    // ==========================================================
    // Tests
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(OFF_TC_STATUS, WORD_RESET);
        rchk(OFF_FAULT_ABORT, WORD_RESET);
        rchk(OFF_CHAN_ON, WORD_RESET);
        rchk(OFF_CHAN_ACTIVE, WORD_RESET);
        onb <= 8'hA5;
        act <= 8'h3C;
        rchk(OFF_CHAN_ON, 32'h000000A5);
        rchk(OFF_CHAN_ACTIVE, 32'h0000003C);
        $display("Test reset and mirrors done");
        fire(8'h04, 8'h00, 8'h00);
        rchk(OFF_FAULT_ABORT, 32'h00000004);
        rchk(OFF_IRQ_STATUS, 32'h00000004);
        irq(1'b1, 1'b1);
        apb(1'b1, OFF_IRQ_CLEAR, 32'h00000004);
        rchk(OFF_FAULT_ABORT, WORD_RESET);
        irq(1'b0, 1'b0);
        fire(8'h00, 8'h20, 8'h00);
        rchk(OFF_FAULT_ABORT, 32'h00200000);
        irq(1'b0, 1'b1);
        apb(1'b1, OFF_IRQ_CLEAR, 32'h00200000);
        rchk(OFF_IRQ_STATUS, WORD_RESET);
        $display("Test fault and abort done");
        apb(1'b1, OFF_IRQ_MASK, 32'h000000FF);
        fire(8'hFF, 8'hFF, 8'h00);
        rchk(OFF_FAULT_ABORT, 32'h00FF00FF);
        irq(1'b0, 1'b1);
        apb(1'b1, OFF_FAULT_ABORT, 32'hFFFFFFFF);
        `CHK(err, 1'b0)
        rchk(OFF_FAULT_ABORT, 32'h00FF00FF);
        apb(1'b1, OFF_IRQ_CLEAR, 32'h00FF00FF);
        apb(1'b1, OFF_IRQ_MASK, 32'h00000000);
        irq(1'b0, 1'b0);
        $display("Test all channels done");
        tcm <= 8'h02;
        fire(8'h00, 8'h00, 8'h02);
        tcm <= 8'h00;
        rchk(OFF_TC_STATUS, WORD_RESET);
        fire(8'h00, 8'h00, 8'h82);
        rchk(OFF_TC_STATUS, 32'h00000082);
        tcm <= 8'h02;
        rchk(OFF_TC_STATUS, 32'h00000080);
        apb(1'b1, OFF_TC_CLEAR, 32'h000000FF);
        tcm <= 8'h00;
        rchk(OFF_TC_STATUS, WORD_RESET);
        apb(1'b0, 12'h0F0, 32'h0);
        `CHK(err, 1'b1)
        $display("Test terminal count done");
        fire(8'h01, 8'h02, 8'h04);
        irq(1'b1, 1'b1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(OFF_FAULT_ABORT, WORD_RESET);
        rchk(OFF_TC_STATUS, WORD_RESET);
        rchk(OFF_IRQ_STATUS, WORD_RESET);
        irq(1'b0, 1'b0);
        $display("Test mid-run reset done");
        final_report;
    end
endmodule
